// ---- hdl/cfg_host.sv ----
// The implementer's own choice: the APB interface to the registers.
module cfg_host
	import cfg_port_pkg::*;
#(
	parameter int SPI_QTR = SPI_QTR_DEF
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	cfg_link_if.host         link
);
	if (SPI_QTR < 1 || SPI_QTR > 63 || 4 * SPI_QTR * PCLK_NS < SPI_MIN_NS) begin : g_chk
		$error("SPI_QTR out of range");
	end

	typedef enum logic [1:0] {
		H_IDLE = 2'h1,
		H_RUN  = 2'h2
	} host_st_t;

	logic        sda_l;
	logic        sdo_l;
	logic        go_r, go_nxt;
	logic [1:0]  op_r, op_nxt;
	logic        fast_r, fast_nxt;
	logic [1:0]  cnt_r, cnt_nxt;
	logic [23:0] lnk_r, lnk_nxt;
	logic        rdy_r, rdy_nxt;
	logic [31:0] prd_r, prd_nxt;
	logic        err_r, err_nxt;
	host_st_t    st_r, st_nxt;
	logic [3:0]  it_r, it_nxt;
	logic [4:0]  bit_r, bit_nxt;
	logic [1:0]  q_r, q_nxt;
	logic [5:0]  qc_r, qc_nxt;
	logic        scl_r, scl_nxt;
	logic        oe_r, oe_nxt;
	logic        o_r, o_nxt;
	logic        cs_r, cs_nxt;
	logic        sel_r, sel_nxt;
	logic [23:0] sh_r, sh_nxt;
	logic [7:0]  in_r, in_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic        nack_r, nack_nxt;
	logic [2:0]  kind;
	logic [7:0]  byt;
	logic        last;
	logic [4:0]  nb;
	logic [3:0]  n_end;
	logic [7:0]  bsh;
	logic        busy;

	cfg_pin_sync #(.IDLE(1'h1)) u_sda (.pclk(pclk), .presetn(presetn),
		.pin(link.serial_data_io_pin), .level(sda_l), .rise(), .fall());
	cfg_pin_sync u_sdo (.pclk(pclk), .presetn(presetn), .pin(link.serial_data_out_pin),
		.level(sdo_l), .rise(), .fall());

	assign busy = go_r | (st_r == H_RUN);

	// APB slave: one wait state, writes ignored while a transfer runs
	always_comb begin
		go_nxt  = 1'h0;
		op_nxt  = op_r;
		fast_nxt = fast_r;
		cnt_nxt = cnt_r;
		lnk_nxt = lnk_r;
		rdy_nxt = psel & penable & ~rdy_r;
		prd_nxt = 32'h0000_0000;
		err_nxt = 1'h0;
		if (psel && penable && !rdy_r) begin
			case (paddr)
				APB_CTRL:  prd_nxt = {26'h0, cnt_r, fast_r, op_r, 1'h0};
				APB_LINK:  prd_nxt = {8'h00, lnk_r};
				APB_STAT:  prd_nxt = {30'h0, nack_r, busy};
				APB_RDATA: prd_nxt = rd_r;
				default:   err_nxt = 1'h1;
			endcase
		end
		if (psel && penable && rdy_r && pwrite && !busy) begin
			if (paddr == APB_CTRL) begin
				go_nxt   = pwdata[CTRL_GO];
				op_nxt   = pwdata[CTRL_OP+:2];
				fast_nxt = pwdata[CTRL_FAST];
				cnt_nxt  = pwdata[CTRL_CNT+:2];
			end else if (paddr == APB_LINK) begin
				lnk_nxt = pwdata[23:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			go_r   <= 1'h0;
			op_r   <= OP_I2C_WR;
			fast_r <= 1'h0;
			cnt_r  <= 2'h0;
			lnk_r  <= 24'h00_0000;
			rdy_r  <= 1'h0;
			prd_r  <= 32'h0000_0000;
			err_r  <= 1'h0;
		end else begin
			go_r   <= go_nxt;
			op_r   <= op_nxt;
			fast_r <= fast_nxt;
			cnt_r  <= cnt_nxt;
			lnk_r  <= lnk_nxt;
			rdy_r  <= rdy_nxt;
			prd_r  <= prd_nxt;
			err_r  <= err_nxt;
		end
	end

	// Slot list of the selected transfer
	always_comb begin
		kind  = K_END;
		byt   = 8'h00;
		last  = 1'h0;
		n_end = 4'h6 + {2'h0, cnt_r};
		if (op_r[1]) begin
			if (it_r == 4'h0)
				kind = K_SPI;
			else if (it_r == 4'h1)
				kind = K_GAP;
		end else if (it_r == 4'h0 || (op_r[0] && it_r == 4'h4)) begin
			kind = K_START;
		end else if (it_r == 4'h1) begin
			kind = K_OUT;
			byt  = {lnk_r[6:0], 1'h0};
		end else if (it_r == 4'h2) begin
			kind = K_OUT;
			byt  = lnk_r[15:8];
		end else if (!op_r[0] && it_r == 4'h3) begin
			kind = K_OUT;
			byt  = lnk_r[23:16];
		end else if (it_r == 4'h3 || (!op_r[0] && it_r == 4'h4)) begin
			kind = K_STOP;
		end else if (op_r[0] && it_r == 4'h5) begin
			kind = K_OUT;
			byt  = {lnk_r[6:0], 1'h1};
		end else if (op_r[0] && it_r > 4'h5 && it_r <= n_end) begin
			kind = K_IN;
			last = (it_r == n_end);
		end else if (op_r[0] && it_r == n_end + 4'h1) begin
			kind = K_STOP;
		end
		case (kind)
			K_OUT, K_IN: nb = BYTE_SLOTS;
			K_SPI:       nb = SPI_FRAME;
			K_GAP:       nb = SPI_GAP_BITS;
			default:     nb = 5'h01;
		endcase
		bsh = byt << bit_r[2:0];
	end

	// Link engine: four quarter steps per bit
	always_comb begin
		st_nxt   = st_r;
		it_nxt   = it_r;
		bit_nxt  = bit_r;
		q_nxt    = q_r;
		qc_nxt   = qc_r;
		scl_nxt  = scl_r;
		oe_nxt   = oe_r;
		o_nxt    = o_r;
		cs_nxt   = cs_r;
		sel_nxt  = sel_r;
		sh_nxt   = sh_r;
		in_nxt   = in_r;
		rd_nxt   = rd_r;
		nack_nxt = nack_r;
		if (go_r) begin
			st_nxt   = H_RUN;
			it_nxt   = 4'h0;
			bit_nxt  = 5'h00;
			q_nxt    = 2'h0;
			qc_nxt   = 6'h00;
			sel_nxt  = ~op_r[1];
			sh_nxt   = {op_r == OP_SPI_WR ? SPI_WR_DIR : SPI_RD_DIR, lnk_r[15:8], lnk_r[23:16]};
			rd_nxt   = 32'h0000_0000;
			nack_nxt = 1'h0;
		end else if (st_r == H_RUN && qc_r != 6'h00) begin
			qc_nxt = qc_r - 6'h01;
		end else if (st_r == H_RUN) begin
			if (op_r[1])
				qc_nxt = 6'(SPI_QTR - 1);
			else if (fast_r)
				qc_nxt = 6'(FAST_QTR - 1);
			else
				qc_nxt = 6'(STD_QTR - 1);
			q_nxt = q_r + 2'h1;
			case (q_r)
				2'h0: begin
					o_nxt = 1'h0;
					case (kind)
						K_OUT: begin
							scl_nxt = 1'h0;
							oe_nxt  = (bit_r != 5'h08) && !bsh[7];
						end
						K_IN: begin
							scl_nxt = 1'h0;
							oe_nxt  = (bit_r == 5'h08) && !last;
						end
						K_SPI: begin
							scl_nxt = 1'h0;
							cs_nxt  = 1'h0;
							oe_nxt  = 1'h1;
							o_nxt   = sh_r[23];
							sh_nxt  = {sh_r[22:0], 1'h0};
						end
						K_START: oe_nxt = 1'h0;
						K_STOP:  oe_nxt = 1'h1;
						K_GAP: begin
							cs_nxt = 1'h1;
							oe_nxt = 1'h0;
						end
						default: st_nxt = H_IDLE;
					endcase
				end
				2'h1: begin
					if (kind != K_GAP)
						scl_nxt = 1'h1;
				end
				2'h2: begin
					if (kind == K_START)
						oe_nxt = 1'h1;
					else if (kind == K_STOP)
						oe_nxt = 1'h0;
					else if (kind == K_OUT && bit_r == 5'h08)
						nack_nxt = nack_r | sda_l;
					else if (kind == K_IN && bit_r != 5'h08)
						in_nxt = {in_r[6:0], sda_l};
					else if (kind == K_IN)
						rd_nxt = {rd_r[23:0], in_r};
					else if (kind == K_SPI && bit_r >= SPI_RD_FIRST)
						in_nxt = {in_r[6:0], sdo_l};
				end
				default: begin
					if (kind != K_STOP && kind != K_GAP)
						scl_nxt = 1'h0;
					if (kind == K_SPI && bit_r == SPI_LAST_RISE && op_r == OP_SPI_RD)
						rd_nxt = {rd_r[23:0], in_r};
					if (bit_r == nb - 5'h01) begin
						bit_nxt = 5'h00;
						it_nxt  = it_r + 4'h1;
					end else begin
						bit_nxt = bit_r + 5'h01;
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r   <= H_IDLE;
			it_r   <= 4'h0;
			bit_r  <= 5'h00;
			q_r    <= 2'h0;
			qc_r   <= 6'h00;
			scl_r  <= 1'h1;
			oe_r   <= 1'h0;
			o_r    <= 1'h0;
			cs_r   <= 1'h1;
			sel_r  <= 1'h1;
			sh_r   <= 24'h00_0000;
			in_r   <= 8'h00;
			rd_r   <= 32'h0000_0000;
			nack_r <= 1'h0;
		end else begin
			st_r   <= st_nxt;
			it_r   <= it_nxt;
			bit_r  <= bit_nxt;
			q_r    <= q_nxt;
			qc_r   <= qc_nxt;
			scl_r  <= scl_nxt;
			oe_r   <= oe_nxt;
			o_r    <= o_nxt;
			cs_r   <= cs_nxt;
			sel_r  <= sel_nxt;
			sh_r   <= sh_nxt;
			in_r   <= in_nxt;
			rd_r   <= rd_nxt;
			nack_r <= nack_nxt;
		end
	end

	assign prdata                      = prd_r;
	assign pready                      = rdy_r;
	assign pslverr                     = err_r;
	assign link.serial_clk             = scl_r;
	assign link.host_sdio_o            = o_r;
	assign link.host_sdio_oe           = oe_r;
	assign link.chip_select_active_low = cs_r;
	assign link.protocol_select_pin    = sel_r;
	assign link.addr_high_o            = lnk_r[7];
	assign link.addr_high_oe           = 1'h0;
	assign link.addr_low_o             = 1'h0;
	assign link.addr_low_oe            = 1'h0;
endmodule : cfg_host

// ---- hdl/cfg_port_pkg.sv ----
package cfg_port_pkg;
	// Rates and derived quarter-bit lengths, rounded up so a rate is never exceeded
	localparam int PCLK_HZ       = 20_000_000;
	localparam int PCLK_NS       = 50;
	localparam int I2C_STD_BPS   = 100_000;
	localparam int I2C_FAST_BPS  = 400_000;
	localparam int SPI_MAX_HZ    = 20_000_000;
	localparam int SPI_PERIOD_NS = 400;
	localparam int STD_QTR       = (PCLK_HZ + 4 * I2C_STD_BPS - 1) / (4 * I2C_STD_BPS);
	localparam int FAST_QTR      = (PCLK_HZ + 4 * I2C_FAST_BPS - 1) / (4 * I2C_FAST_BPS);
	localparam int SPI_QTR_DEF   = (SPI_PERIOD_NS + 4 * PCLK_NS - 1) / (4 * PCLK_NS);
	localparam int SPI_MIN_NS    = 1_000_000_000 / SPI_MAX_HZ;
	// Slave address and device registers
	localparam logic [4:0] FIXED_UPPER = 5'h1B;
	localparam logic [4:0] ALT_UPPER   = 5'h1A;
	localparam logic [7:0] REG_OVR     = 8'h2A;
	localparam logic [7:0] REG_RST     = 8'hFE;
	localparam logic [7:0] REG_PAGE    = 8'hFF;
	localparam logic [7:0] RST_ON      = 8'h01;
	localparam int         OVR_EN      = 7;
	localparam int         OVR_HI      = 6;
	localparam int         OVR_LO      = 2;
	// Four-wire frame positions, counted in rising edges already seen
	localparam logic [4:0] SPI_DIR_RISE  = 5'h07;
	localparam logic [4:0] SPI_ADDR_RISE = 5'h0F;
	localparam logic [4:0] SPI_LAST_RISE = 5'h17;
	localparam logic [4:0] SPI_RD_FIRST  = 5'h10;
	localparam logic [4:0] SPI_FRAME     = 5'h18;
	localparam logic [4:0] SPI_GAP_BITS  = 5'h02;
	localparam logic [4:0] BYTE_SLOTS    = 5'h09;
	localparam logic [7:0] SPI_WR_DIR    = 8'h01;
	localparam logic [7:0] SPI_RD_DIR    = 8'h00;
	// Host command registers on APB
	localparam logic [7:0] APB_CTRL  = 8'h00;
	localparam logic [7:0] APB_LINK  = 8'h04;
	localparam logic [7:0] APB_STAT  = 8'h08;
	localparam logic [7:0] APB_RDATA = 8'h0C;
	localparam int         CTRL_GO   = 0;
	localparam int         CTRL_OP   = 1;
	localparam int         CTRL_FAST = 3;
	localparam int         CTRL_CNT  = 4;
	localparam logic [1:0] OP_I2C_WR = 2'h0;
	localparam logic [1:0] OP_I2C_RD = 2'h1;
	localparam logic [1:0] OP_SPI_WR = 2'h2;
	localparam logic [1:0] OP_SPI_RD = 2'h3;
	// Host link slot kinds
	localparam logic [2:0] K_START = 3'h0;
	localparam logic [2:0] K_STOP  = 3'h1;
	localparam logic [2:0] K_OUT   = 3'h2;
	localparam logic [2:0] K_IN    = 3'h3;
	localparam logic [2:0] K_SPI   = 3'h4;
	localparam logic [2:0] K_GAP   = 3'h5;
	localparam logic [2:0] K_END   = 3'h6;
endpackage : cfg_port_pkg

// ---- hdl/cfg_link_if.sv ----
interface cfg_link_if;
	logic serial_clk;
	logic host_sdio_o;
	logic host_sdio_oe;
	logic dev_sdio_o;
	logic dev_sdio_oe;
	logic serial_data_io_pin;
	logic serial_data_out_pin;
	logic chip_select_active_low;
	logic protocol_select_pin;
	logic addr_high_o;
	logic addr_high_oe;
	logic addr_low_o;
	logic addr_low_oe;
	logic address_pin_high;
	logic address_pin_low;
	// Data wire: an enabled driver sets the level, a released wire floats high
	assign serial_data_io_pin = (host_sdio_oe ? host_sdio_o : 1'h1)
		& (dev_sdio_oe ? dev_sdio_o : 1'h1);
	// Floating address pins: high one pulled down, low one pulled up
	assign address_pin_high = addr_high_oe ? addr_high_o : 1'h0;
	assign address_pin_low  = addr_low_oe ? addr_low_o : 1'h1;
	modport host (output serial_clk, host_sdio_o, host_sdio_oe, chip_select_active_low,
		protocol_select_pin, addr_high_o, addr_high_oe, addr_low_o, addr_low_oe,
		input serial_data_io_pin, serial_data_out_pin);
	modport dev (input serial_clk, serial_data_io_pin, chip_select_active_low,
		protocol_select_pin, address_pin_high, address_pin_low,
		output dev_sdio_o, dev_sdio_oe, serial_data_out_pin);
endinterface : cfg_link_if

// ---- hdl/cfg_pin_sync.sv ----
// IDLE is the pin's resting level, so leaving reset shows no false edge
module cfg_pin_sync #(
	parameter logic IDLE = 1'h0
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	// Two stages against metastability, a third for edge finding
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= IDLE;
			s2_r <= IDLE;
			s3_r <= IDLE;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	assign level = s2_r;
	assign rise  = s2_r & ~s3_r;
	assign fall  = ~s2_r & s3_r;
endmodule : cfg_pin_sync

// ---- hdl/cfg_dev.sv ----
module cfg_dev
	import cfg_port_pkg::*;
#(
	parameter int PAGES = 2
) (
	input  wire logic  pclk,
	input  wire logic  presetn,
	cfg_link_if.dev    link,
	output logic       chip_in_reset,
	output logic [7:0] page_sel,
	output logic [6:0] slave_addr
);
	localparam int PAGE_W = $clog2(PAGES);
	if (PAGES < 2 || PAGES > 256 || (PAGES & (PAGES - 1)) != 0) begin : g_chk
		$error("PAGES must be a power of two from 2 to 256");
	end

	typedef enum logic [5:0] {
		I_IDLE = 6'h01,
		I_ADDR = 6'h02,
		I_ACK  = 6'h04,
		I_RX   = 6'h08,
		I_TX   = 6'h10,
		I_TACK = 6'h20
	} i2c_st_t;

	logic       scl_l;
	logic       scl_rise;
	logic       scl_fall;
	logic       sda_l;
	logic       sda_rise;
	logic       sda_fall;
	logic       cs_l;
	logic       sel_l;
	logic       a1_l;
	logic       a0_l;
	logic [7:0] mem [PAGES * 256];
	logic [7:0] ovr_r, ovr_nxt;
	logic [7:0] rst_r, rst_nxt;
	logic [7:0] page_r, page_nxt;
	logic       in_rst_r, in_rst_nxt;
	logic [6:0] saddr_r, saddr_nxt;
	logic       wr_en;
	logic [7:0] wr_a;
	logic [7:0] wr_d;
	logic       i_wr;
	logic       s_wr;
	logic [7:0] s_wd;
	i2c_st_t    ist_r, ist_nxt;
	logic [3:0] icnt_r, icnt_nxt;
	logic [7:0] ish_r, ish_nxt;
	logic       rw_r, rw_nxt;
	logic [1:0] ibyte_r, ibyte_nxt;
	logic [7:0] ireg_r, ireg_nxt;
	logic       oe_r, oe_nxt;
	logic [4:0] scnt_r, scnt_nxt;
	logic [7:0] ssh_r, ssh_nxt;
	logic       dir_r, dir_nxt;
	logic [7:0] sreg_r, sreg_nxt;
	logic [7:0] rbuf_r, rbuf_nxt;
	logic       sdo_r, sdo_nxt;
	logic [7:0] i_rd;
	logic [7:0] s_rd;

	cfg_pin_sync #(.IDLE(1'h1)) u_scl (.pclk(pclk), .presetn(presetn), .pin(link.serial_clk),
		.level(scl_l), .rise(scl_rise), .fall(scl_fall));
	cfg_pin_sync #(.IDLE(1'h1)) u_sda (.pclk(pclk), .presetn(presetn),
		.pin(link.serial_data_io_pin), .level(sda_l), .rise(sda_rise), .fall(sda_fall));
	cfg_pin_sync #(.IDLE(1'h1)) u_cs (.pclk(pclk), .presetn(presetn),
		.pin(link.chip_select_active_low), .level(cs_l), .rise(), .fall());
	cfg_pin_sync #(.IDLE(1'h1)) u_sel (.pclk(pclk), .presetn(presetn),
		.pin(link.protocol_select_pin), .level(sel_l), .rise(), .fall());
	cfg_pin_sync u_a1 (.pclk(pclk), .presetn(presetn), .pin(link.address_pin_high),
		.level(a1_l), .rise(), .fall());
	cfg_pin_sync u_a0 (.pclk(pclk), .presetn(presetn), .pin(link.address_pin_low),
		.level(a0_l), .rise(), .fall());

	// Read mux over the selected page; page and control registers come from flops
	function automatic logic [7:0] rd_f(input logic [7:0] a);
		if (a == REG_PAGE)
			return page_r;
		else if (page_r == 8'h00 && a == REG_OVR)
			return ovr_r;
		else if (page_r == 8'h00 && a == REG_RST)
			return rst_r;
		else
			return mem[{page_r[PAGE_W-1:0], a}];
	endfunction : rd_f

	assign i_rd  = rd_f(ireg_r);
	assign s_rd  = rd_f(sreg_r);
	assign wr_en = sel_l ? i_wr : s_wr;
	assign wr_a  = sel_l ? ireg_r : sreg_r;
	assign wr_d  = sel_l ? ish_r : s_wd;

	// Register map side effects and effective slave address
	always_comb begin
		ovr_nxt    = ovr_r;
		rst_nxt    = rst_r;
		page_nxt   = page_r;
		in_rst_nxt = (rst_r == RST_ON);
		if (in_rst_r)
			saddr_nxt = {ALT_UPPER, a1_l, a0_l};
		else if (ovr_r[OVR_EN])
			saddr_nxt = {ovr_r[OVR_HI:OVR_LO], a1_l, a0_l};
		else
			saddr_nxt = {FIXED_UPPER, a1_l, a0_l};
		if (wr_en) begin
			if (wr_a == REG_PAGE)
				page_nxt = wr_d;
			if (page_r == 8'h00 && wr_a == REG_OVR)
				ovr_nxt = wr_d;
			if (page_r == 8'h00 && wr_a == REG_RST)
				rst_nxt = wr_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovr_r    <= 8'h00;
			rst_r    <= 8'h00;
			page_r   <= 8'h00;
			in_rst_r <= 1'h0;
			saddr_r  <= {FIXED_UPPER, 2'h2};
		end else begin
			ovr_r    <= ovr_nxt;
			rst_r    <= rst_nxt;
			page_r   <= page_nxt;
			in_rst_r <= in_rst_nxt;
			saddr_r  <= saddr_nxt;
		end
	end

	// Storage array, written by whichever port is selected
	always_ff @(posedge pclk) begin
		if (wr_en)
			mem[{page_r[PAGE_W-1:0], wr_a}] <= wr_d;
	end

	// Two-wire slave: start and stop seen while the clock is high
	always_comb begin
		ist_nxt   = ist_r;
		icnt_nxt  = icnt_r;
		ish_nxt   = ish_r;
		rw_nxt    = rw_r;
		ibyte_nxt = ibyte_r;
		ireg_nxt  = ireg_r;
		oe_nxt    = oe_r;
		i_wr      = 1'h0;
		if (!sel_l) begin
			ist_nxt = I_IDLE;
			oe_nxt  = 1'h0;
		end else if (sda_rise && scl_l) begin
			ist_nxt = I_IDLE;
			oe_nxt  = 1'h0;
		end else if (sda_fall && scl_l) begin
			ist_nxt  = I_ADDR;
			icnt_nxt = 4'h0;
			oe_nxt   = 1'h0;
		end else begin
			case (ist_r)
				I_ADDR, I_RX: begin
					if (scl_rise && icnt_r != 4'h8) begin
						ish_nxt  = {ish_r[6:0], sda_l};
						icnt_nxt = icnt_r + 4'h1;
					end else if (scl_fall && icnt_r == 4'h8) begin
						if (ist_r == I_ADDR) begin
							if (ish_r[7:1] == saddr_r) begin
								oe_nxt    = 1'h1;
								rw_nxt    = ish_r[0];
								ibyte_nxt = 2'h0;
								ist_nxt   = I_ACK;
							end else begin
								ist_nxt = I_IDLE;
							end
						end else if (ibyte_r == 2'h0) begin
							ireg_nxt  = ish_r;
							oe_nxt    = 1'h1;
							ibyte_nxt = 2'h1;
							ist_nxt   = I_ACK;
						end else if (ibyte_r == 2'h1) begin
							i_wr      = 1'h1;
							oe_nxt    = 1'h1;
							ibyte_nxt = 2'h2;
							ist_nxt   = I_ACK;
						end else begin
							ist_nxt = I_IDLE;
						end
					end
				end
				I_ACK: begin
					if (scl_fall) begin
						icnt_nxt = 4'h0;
						if (rw_r) begin
							ish_nxt  = {i_rd[6:0], 1'h0};
							oe_nxt   = ~i_rd[7];
							icnt_nxt = 4'h1;
							ist_nxt  = I_TX;
						end else begin
							oe_nxt  = 1'h0;
							ist_nxt = I_RX;
						end
					end
				end
				I_TX: begin
					if (scl_fall && icnt_r == 4'h8) begin
						oe_nxt  = 1'h0;
						ist_nxt = I_TACK;
					end else if (scl_fall) begin
						oe_nxt   = ~ish_r[7];
						ish_nxt  = {ish_r[6:0], 1'h0};
						icnt_nxt = icnt_r + 4'h1;
					end
				end
				I_TACK: begin
					if (scl_rise && !sda_l) begin
						ireg_nxt = ireg_r + 8'h01;
						ist_nxt  = I_ACK;
					end else if (scl_rise) begin
						ist_nxt = I_IDLE;
					end
				end
				default: ist_nxt = I_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ist_r   <= I_IDLE;
			icnt_r  <= 4'h0;
			ish_r   <= 8'h00;
			rw_r    <= 1'h0;
			ibyte_r <= 2'h0;
			ireg_r  <= 8'h00;
			oe_r    <= 1'h0;
		end else begin
			ist_r   <= ist_nxt;
			icnt_r  <= icnt_nxt;
			ish_r   <= ish_nxt;
			rw_r    <= rw_nxt;
			ibyte_r <= ibyte_nxt;
			ireg_r  <= ireg_nxt;
			oe_r    <= oe_nxt;
		end
	end

	// Four-wire slave: sample on rising edges, shift read data on falling edges
	always_comb begin
		scnt_nxt = scnt_r;
		ssh_nxt  = ssh_r;
		dir_nxt  = dir_r;
		sreg_nxt = sreg_r;
		rbuf_nxt = rbuf_r;
		sdo_nxt  = sdo_r;
		s_wr     = 1'h0;
		s_wd     = {ssh_r[6:0], sda_l};
		if (sel_l || cs_l) begin
			scnt_nxt = 5'h00;
			if (!sel_l && scl_rise)
				sdo_nxt = 1'h0;
		end else if (scl_rise && scnt_r != SPI_FRAME) begin
			ssh_nxt  = {ssh_r[6:0], sda_l};
			scnt_nxt = scnt_r + 5'h01;
			if (scnt_r == SPI_DIR_RISE)
				dir_nxt = sda_l;
			if (scnt_r == SPI_ADDR_RISE)
				sreg_nxt = {ssh_r[6:0], sda_l};
			if (scnt_r == SPI_LAST_RISE && dir_r)
				s_wr = 1'h1;
		end else if (scl_fall && !dir_r && scnt_r >= SPI_RD_FIRST && scnt_r != SPI_FRAME) begin
			if (scnt_r == SPI_RD_FIRST) begin
				sdo_nxt  = s_rd[7];
				rbuf_nxt = {s_rd[6:0], 1'h0};
			end else begin
				sdo_nxt  = rbuf_r[7];
				rbuf_nxt = {rbuf_r[6:0], 1'h0};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scnt_r <= 5'h00;
			ssh_r  <= 8'h00;
			dir_r  <= 1'h0;
			sreg_r <= 8'h00;
			rbuf_r <= 8'h00;
			sdo_r  <= 1'h0;
		end else begin
			scnt_r <= scnt_nxt;
			ssh_r  <= ssh_nxt;
			dir_r  <= dir_nxt;
			sreg_r <= sreg_nxt;
			rbuf_r <= rbuf_nxt;
			sdo_r  <= sdo_nxt;
		end
	end

	assign link.dev_sdio_o         = 1'h0;
	assign link.dev_sdio_oe        = oe_r;
	assign link.serial_data_out_pin = sdo_r;
	assign chip_in_reset           = in_rst_r;
	assign page_sel                = page_r;
	assign slave_addr              = saddr_r;
endmodule : cfg_dev

// ---- sim/cfg_port_sva.sv ----
module cfg_port_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic serial_clk,
	input wire logic chip_select_active_low,
	input wire logic protocol_select_pin,
	input wire logic dev_sdio_oe,
	input wire logic serial_data_out_pin
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       sclk_r, sclk_nxt;
	logic [4:0] rises_r, rises_nxt;
	logic [5:0] hi_r, hi_nxt;
	// Link clock rises within a frame, pclk cycles of deselect
	always_comb begin
		sclk_nxt  = serial_clk;
		rises_nxt = chip_select_active_low ? 5'h00 : rises_r + 5'(serial_clk & !sclk_r);
		hi_nxt    = !chip_select_active_low ? 6'h00 : hi_r + 6'(hi_r != 6'h3F);
	end
	// Helper registers only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_r  <= 1'h1;
			rises_r <= 5'h00;
			hi_r    <= 6'h3F;
		end else begin
			sclk_r  <= sclk_nxt;
			rises_r <= rises_nxt;
			hi_r    <= hi_nxt;
		end
	end
	sequence four_wire_held;
		!protocol_select_pin [*3];
	endsequence
	sequence clk_held_high;
		serial_clk [*2];
	endsequence
	dev_spi_quiet_a: assert property (four_wire_held |-> !dev_sdio_oe)
		else $error("data wire driven in four-wire mode");
	ack_on_low_a: assert property (protocol_select_pin && $changed(dev_sdio_oe) |-> !serial_clk)
		else $error("data wire changed with clock high");
	no_echo_a: assert property (!chip_select_active_low && rises_r < 5'h10
		|-> $stable(serial_data_out_pin))
		else $error("output moved before read data");
	sdo_edge_a: assert property (!chip_select_active_low && $changed(serial_data_out_pin)
		|-> !serial_clk)
		else $error("output changed with clock high");
	frame_len_a: assert property (!chip_select_active_low |-> rises_r <= 5'h18)
		else $error("frame longer than 24 bits");
	cs_gap_a: assert property ($fell(chip_select_active_low) |-> hi_r >= 6'h18)
		else $error("deselect gap too short");
	spi_rate_a: assert property (!chip_select_active_low && $rose(serial_clk)
		|-> clk_held_high)
		else $error("four-wire clock too fast");
	i2c_rate_a: assert property (protocol_select_pin && $rose(serial_clk) |-> serial_clk [*8])
		else $error("two-wire clock too fast");
endmodule : cfg_port_sva

// ---- sim/dual_serial_config_port_test.sv ----
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module dual_serial_config_port_test import cfg_port_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, chip_in_reset;
	logic [7:0]  page_sel;
	logic [6:0]  slave_addr;
	int          fails = 0, cmp_count = 0, cycles = 0;
	cfg_link_if i_cfg_link_if ();
	cfg_host #(.SPI_QTR(3)) i_cfg_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .link(i_cfg_link_if));
	cfg_dev i_cfg_dev (.pclk, .presetn, .link(i_cfg_link_if), .chip_in_reset, .page_sel,
		.slave_addr);
	cfg_port_sva i_cfg_port_sva (.pclk, .presetn, .serial_clk(i_cfg_link_if.serial_clk),
		.chip_select_active_low(i_cfg_link_if.chip_select_active_low),
		.protocol_select_pin(i_cfg_link_if.protocol_select_pin),
		.dev_sdio_oe(i_cfg_link_if.dev_sdio_oe),
		.serial_data_out_pin(i_cfg_link_if.serial_data_out_pin));
	// Clock and hang guard
	always #25 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 60000) begin
			fails++;
			wrap_up();
		end
	end
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// Control word: count, rate, operation, go
	function automatic logic [5:0] cw(logic [1:0] op, logic f, logic [1:0] n);
		return {n, f, op, 1'h1};
	endfunction : cw
	// Load link fields, start, poll until idle; rd ends holding status
	task automatic xfer(input logic [5:0] c, input logic [6:0] sa, input logic [7:0] ra,
		input logic [7:0] wd);
		apb(1'h1, APB_LINK, {8'h00, wd, ra, 1'h0, sa});
		apb(1'h1, APB_CTRL, {26'h0, c});
		rd = 32'h1;
		while (rd[0] !== 1'h0) apb(1'h0, APB_STAT, 32'h0);
	endtask : xfer
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up
	// Main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		repeat (4) @(posedge pclk);
		`CHK("slave_addr", 7'h6D, slave_addr)
		xfer(cw(OP_I2C_WR, 1'h0, 2'h0), 7'h6D, 8'h10, 8'hA5);
		`CHK("nack", 1'h0, rd[1])
		xfer(cw(OP_I2C_WR, 1'h1, 2'h0), 7'h6D, 8'h11, 8'h3C);
		xfer(cw(OP_I2C_RD, 1'h1, 2'h1), 7'h6D, 8'h10, 8'h00);
		apb(1'h0, APB_RDATA, 32'h0);
		`CHK("burst read", 32'h0000A53C, rd)
		xfer(cw(OP_I2C_WR, 1'h1, 2'h0), 7'h6C, 8'h12, 8'h55);
		`CHK("nack", 1'h1, rd[1])
		xfer(cw(OP_SPI_WR, 1'h0, 2'h0), 7'h00, 8'h20, 8'h96);
		xfer(cw(OP_SPI_RD, 1'h0, 2'h0), 7'h00, 8'h20, 8'h00);
		apb(1'h0, APB_RDATA, 32'h0);
		`CHK("four-wire read", 32'h00000096, rd)
		xfer(cw(OP_SPI_WR, 1'h0, 2'h0), 7'h00, REG_PAGE, 8'h01);
		`CHK("page_sel", 8'h01, page_sel)
		xfer(cw(OP_SPI_WR, 1'h0, 2'h0), 7'h00, 8'h11, 8'h77);
		xfer(cw(OP_SPI_WR, 1'h0, 2'h0), 7'h00, REG_PAGE, 8'h00);
		xfer(cw(OP_SPI_RD, 1'h0, 2'h0), 7'h00, 8'h11, 8'h00);
		apb(1'h0, APB_RDATA, 32'h0);
		`CHK("page 0 byte", 32'h0000003C, rd)
		xfer(cw(OP_I2C_WR, 1'h1, 2'h0), 7'h6D, REG_OVR, 8'h94);
		`CHK("slave_addr", 7'h15, slave_addr)
		xfer(cw(OP_I2C_WR, 1'h1, 2'h0), 7'h15, REG_RST, RST_ON);
		`CHK("slave_addr", 7'h69, slave_addr)
		`CHK("chip_in_reset", 1'h1, chip_in_reset)
		xfer(cw(OP_I2C_WR, 1'h1, 2'h0), 7'h69, REG_RST, 8'h00);
		`CHK("slave_addr", 7'h15, slave_addr)
		apb(1'h0, 8'h40, 32'h0);
		`CHK("pslverr", 1'h1, err)
		wrap_up();
	end
endmodule : dual_serial_config_port_test
